// *** src/ecfd_pkg.sv ***
package ecfd_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets on the bus.
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADR_UNIT   = 8'h00;
   localparam logic [7:0] ADR_PRESC  = 8'h04;
   localparam logic [7:0] ADR_MODE   = 8'h08;
   localparam logic [7:0] ADR_RELOAD = 8'h0C;
   localparam logic [7:0] ADR_COUNT  = 8'h10;
   localparam logic [7:0] ADR_TRIG   = 8'h14;
   localparam logic [7:0] ADR_STAT   = 8'h18;
   localparam logic [7:0] ADR_OLVL   = 8'h1C;
   localparam logic [7:0] ADR_OEN    = 8'h20;
   localparam logic [7:0] ADR_OPOL   = 8'h24;
   localparam logic [7:0] ADR_OFUN   = 8'h28;

   // ----------------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------------
   localparam int MD_START_IRQ = 0;
   localparam int MD_MODE_LO   = 1;
   localparam int MD_EDGE_LO   = 6;
   localparam int MD_TRIG_LO   = 8;
   localparam int MD_MASTER    = 11;
   localparam int MD_CCS_LO    = 12;
   localparam int MD_CKS       = 15;
   localparam int TRIG_GO      = 0;
   localparam int TRIG_HALT    = 1;
   localparam int STAT_ACTIVE  = 0;
   localparam int STAT_OUT     = 1;
   localparam int UNIT_EN      = 0;

   // ----------------------------------------------------------------------
   // Codes and reset values.
   // ----------------------------------------------------------------------
   localparam logic [3:0]  MODE_INTERVAL = 4'h0;
   localparam logic [3:0]  MODE_EVENT    = 4'h3;
   localparam logic [1:0]  EDGE_FALL     = 2'h0;
   localparam logic [1:0]  EDGE_RISE     = 2'h1;
   localparam logic [1:0]  EDGE_BOTH     = 2'h2;
   localparam logic [1:0]  CCS_PIN       = 2'h1;
   localparam logic [2:0]  STS_SW        = 3'h0;
   localparam logic [3:0]  FD_CH_A       = 4'hA;
   localparam logic [3:0]  FD_CH_B       = 4'hB;
   localparam logic [3:0]  GRP_HI_FIRST  = 4'h8;
   localparam logic [15:0] RST_REG16     = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } ecfd_state_t;

endpackage : ecfd_pkg

// *** src/ecfd_edge_if.sv ***
`timescale 1ns/1ps
// Carries the operation clock tick, edge selection and count enable.
interface ecfd_edge_if;
   logic       op_tick;
   logic [1:0] edge_sel;
   logic       enable;
   logic       cnt_en;

   modport clk  (output op_tick);
   modport det  (input op_tick, input edge_sel, input enable, output cnt_en);
   modport core (input op_tick, input cnt_en, output edge_sel, output enable);
endinterface : ecfd_edge_if

// *** src/ecfd_opclk.sv ***
`timescale 1ns/1ps
module ecfd_opclk #(
   parameter logic [3:0] CH_IDX = 4'hA
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [15:0] presc_i,
   input  wire logic        cks_i,
   ecfd_edge_if.clk         ck_if
);

   logic [15:0] div_r;
   logic        tick_r;
   logic [1:0]  fsel;

   // Tick when the low k bits of the divider are all ones: divide by 2^k.
   function automatic logic tick_of(input logic [3:0] k, input logic [15:0] cnt);
      logic [15:0] m;
      m = (16'h0001 << k) - 16'h0001;
      return (cnt & m) == m;
   endfunction : tick_of

   assign fsel = {CH_IDX >= ecfd_pkg::GRP_HI_FIRST, cks_i};

   // ----------------------------------------------------------------------
   // Divider; held in reset while the unit is off, so the clock stops.
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_r  <= 16'h0000;
         tick_r <= 1'b0;
      end
      else
      begin
         div_r  <= div_r + 16'h0001;
         tick_r <= tick_of(presc_i[fsel*4 +: 4], div_r);
      end
   end

   assign ck_if.op_tick = tick_r;

endmodule : ecfd_opclk

// *** src/ecfd_edge_det.sv ***
`timescale 1ns/1ps
module ecfd_edge_det (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic event_input_pin_i,
   ecfd_edge_if.det  det_if
);

   logic sync1_r;
   logic sync2_r;
   logic samp_r;
   logic cnt_en_r;

   // Reserved code 11 detects nothing, so a bad setting cannot count.
   function automatic logic edge_hit(input logic [1:0] sel, input logic o,
                                     input logic n);
      case (sel)
         ecfd_pkg::EDGE_FALL: return o & ~n;
         ecfd_pkg::EDGE_RISE: return ~o & n;
         ecfd_pkg::EDGE_BOTH: return o ^ n;
         default:             return 1'b0;
      endcase
   endfunction : edge_hit

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end
      else
      begin
         sync1_r <= event_input_pin_i;
         sync2_r <= sync1_r;
      end
   end

   // sample on op tick
   // The level is only looked at on operation clock ticks, which costs up to
   // one operation clock period of jitter on every detected edge.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         samp_r   <= 1'b0;
         cnt_en_r <= 1'b0;
      end
      else if (det_if.op_tick)
      begin
         samp_r   <= sync2_r;
         cnt_en_r <= det_if.enable & edge_hit(det_if.edge_sel, samp_r, sync2_r);
      end
      else
      begin
         cnt_en_r <= 1'b0;
      end
   end

   assign det_if.cnt_en = cnt_en_r;

endmodule : ecfd_edge_det

// *** src/ecfd_channel.sv ***
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Mode code 0011 selects event counting; counter counts down.
// - Event mode start loads the reload value at once, then waits edges.
// - Each edge decrements; at zero reload and raise the interrupt, repeat.
// - Edge codes: 00 falling, 01 rising, 10 both; 11 must not be used.
// - Count source 01 counts pin edges instead of the operation clock.
// - Trigger source 000 allows software start only.
// - Start-interrupt bit 0: no interrupt, no toggle when counting starts.
// - Reload writes take effect from the next count period only.
// - Start and stop bits self-clear; start sets the active flag.
// - Stop clears the active flag; counter halts and holds its value.
// - Unit enable low stops the clock, ignores writes, resets everything; here the unit enable bit itself still takes writes and keeps its value.
// - Divider mode loads at first edge; optional interrupt and toggle then.
// - Divider mode: each edge decrements; at zero toggle output and reload.
// - Output equals input over twice reload plus one for single edges.
// - Input edges are sampled with the operation clock.
// - Divider mode exists only on channels 10 and 11.
// - Operation clock select picks the first or second clock of the group.
// - Output level bit sets idle level; enable bit lets counting drive it.
module ecfd_channel #(
   parameter logic [3:0] CH_IDX = 4'hA
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        event_input_pin_i,
   output logic             timer_output_pin_o,
   output logic             channel_irq_o
);

   // ----------------------------------------------------------------------
   // Storage and decoded fields.
   // ----------------------------------------------------------------------
   logic                  unit_en_r;
   logic [15:0]           presc_r;
   logic [15:0]           mode_r;
   logic [15:0]           reload_r;
   logic [15:0]           counter_r;
   logic                  active_r;
   ecfd_pkg::ecfd_state_t state_r;
   logic                  oen_r;
   logic                  opol_r;
   logic                  ofun_r;
   logic                  ack_r;
   logic [31:0]           dat_r;
   logic                  irq_r;
   logic                  tout_r;
   logic [31:0]           rd_nxt;
   logic                  irq_nxt;
   logic                  req;
   logic                  wr_fire;
   logic                  wr_ok;
   logic                  unit_rst;
   logic [7:0]            adr_w;
   logic                  lane;
   logic                  go;
   logic                  halt;
   logic                  cnt_step;
   logic                  is_event;
   logic                  is_fd;
   logic                  fd_ch;
   logic                  start_irq;
   logic [3:0]            op_mode;
   logic [1:0]            ccs;
   logic [2:0]            trig_src;
   logic                  start_evt;
   logic                  wait_evt;
   logic                  reload_evt;

   ecfd_edge_if eif ();

   // Byte-lane merge for the 16-bit registers.
   function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
      return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction : merge16

   assign op_mode   = mode_r[ecfd_pkg::MD_MODE_LO +: 4];
   assign start_irq = mode_r[ecfd_pkg::MD_START_IRQ];
   assign ccs       = mode_r[ecfd_pkg::MD_CCS_LO +: 2];
   assign trig_src  = mode_r[ecfd_pkg::MD_TRIG_LO +: 3];
   assign is_event  = op_mode == ecfd_pkg::MODE_EVENT;
   assign fd_ch     = (CH_IDX == ecfd_pkg::FD_CH_A) || (CH_IDX == ecfd_pkg::FD_CH_B);
   assign is_fd     = fd_ch && op_mode == ecfd_pkg::MODE_INTERVAL
                      && ccs == ecfd_pkg::CCS_PIN;
   assign cnt_step  = (ccs == ecfd_pkg::CCS_PIN) ? eif.cnt_en : eif.op_tick;

   // ----------------------------------------------------------------------
   // Bus slave: ack one cycle after the request, writes land on the ack edge.
   // ----------------------------------------------------------------------
   assign req      = wb_cyc_i & wb_stb_i;
   assign wr_fire  = req & wb_we_i & ack_r;
   assign wr_ok    = wr_fire & unit_en_r;
   assign unit_rst = rst_i | ~unit_en_r;
   assign adr_w    = {wb_adr_i[7:2], 2'b00};
   assign lane     = CH_IDX[3] ? wb_sel_i[1] : wb_sel_i[0];

   // software start only
   // Other trigger sources would be hardware triggers, which this channel has
   // none of, so the start bit only acts with source code 000; the stop bit acts with any source.
   // triggers never stored
   assign go   = wr_ok && adr_w == ecfd_pkg::ADR_TRIG && wb_sel_i[0]
                 && wb_dat_i[ecfd_pkg::TRIG_GO] && trig_src == ecfd_pkg::STS_SW;
   assign halt = wr_ok && adr_w == ecfd_pkg::ADR_TRIG && wb_sel_i[0]
                 && wb_dat_i[ecfd_pkg::TRIG_HALT];

   // Ack handshake; drops the cycle after it was given.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= req & ~ack_r;
      end
   end

   // Read data mux; trigger bits always read as zero.
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      case (adr_w)
         ecfd_pkg::ADR_UNIT:   rd_nxt[ecfd_pkg::UNIT_EN] = unit_en_r;
         ecfd_pkg::ADR_PRESC:  rd_nxt[15:0] = presc_r;
         ecfd_pkg::ADR_MODE:   rd_nxt[15:0] = mode_r;
         ecfd_pkg::ADR_RELOAD: rd_nxt[15:0] = reload_r;
         ecfd_pkg::ADR_COUNT:  rd_nxt[15:0] = counter_r;
         ecfd_pkg::ADR_STAT:
         begin
            rd_nxt[ecfd_pkg::STAT_ACTIVE] = active_r;
            rd_nxt[ecfd_pkg::STAT_OUT]    = tout_r;
         end
         ecfd_pkg::ADR_OLVL:   rd_nxt[CH_IDX] = tout_r;
         ecfd_pkg::ADR_OEN:    rd_nxt[CH_IDX] = oen_r;
         ecfd_pkg::ADR_OPOL:   rd_nxt[CH_IDX] = opol_r;
         ecfd_pkg::ADR_OFUN:   rd_nxt[CH_IDX] = ofun_r;
         default:              rd_nxt = 32'h0000_0000;
      endcase
   end

   // Read data is captured as the ack is raised and held until the next one.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dat_r <= 32'h0000_0000;
      end
      else if (req & ~ack_r)
      begin
         dat_r <= rd_nxt;
      end
   end

   // Unit enable itself survives the unit reset so software can turn it on.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         unit_en_r <= 1'b0;
      end
      else if (wr_fire && adr_w == ecfd_pkg::ADR_UNIT && wb_sel_i[0])
      begin
         unit_en_r <= wb_dat_i[ecfd_pkg::UNIT_EN];
      end
   end

   // ----------------------------------------------------------------------
   // Configuration registers.
   // ----------------------------------------------------------------------
   // reinitialised when off
   always_ff @(posedge clk_i)
   begin
      if (unit_rst)
      begin
         presc_r  <= ecfd_pkg::RST_REG16;
         mode_r   <= ecfd_pkg::RST_REG16;
         reload_r <= ecfd_pkg::RST_REG16;
         oen_r    <= 1'b0;
         opol_r   <= 1'b0;
         ofun_r   <= 1'b0;
      end
      else if (wr_ok)
      begin
         case (adr_w)
            ecfd_pkg::ADR_PRESC:  presc_r  <= merge16(presc_r, wb_dat_i, wb_sel_i);
            ecfd_pkg::ADR_MODE:   mode_r   <= merge16(mode_r, wb_dat_i, wb_sel_i);
            ecfd_pkg::ADR_RELOAD: reload_r <= merge16(reload_r, wb_dat_i, wb_sel_i);
            ecfd_pkg::ADR_OEN:    oen_r    <= lane ? wb_dat_i[CH_IDX] : oen_r;
            ecfd_pkg::ADR_OPOL:   opol_r   <= lane ? wb_dat_i[CH_IDX] : opol_r;
            ecfd_pkg::ADR_OFUN:   ofun_r   <= lane ? wb_dat_i[CH_IDX] : ofun_r;
            default:              presc_r  <= presc_r;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Counting engine.
   // ----------------------------------------------------------------------
   assign start_evt  = go && !halt && is_event;
   assign wait_evt   = state_r == ecfd_pkg::ST_WAIT && cnt_step && !halt;
   assign reload_evt = state_r == ecfd_pkg::ST_RUN && cnt_step && !halt && !go
                       && counter_r == 16'h0000;
   assign irq_nxt    = reload_evt | ((start_evt | wait_evt) & start_irq);

   // Stop wins over start when both bits are written together.
   always_ff @(posedge clk_i)
   begin
      if (unit_rst)
      begin
         state_r   <= ecfd_pkg::ST_IDLE;
         counter_r <= ecfd_pkg::RST_REG16;
         active_r  <= 1'b0;
      end
      else if (halt)
      begin
         state_r  <= ecfd_pkg::ST_IDLE;
         active_r <= 1'b0;
      end
      else if (go)
      begin
         active_r <= 1'b1;
         if (is_fd)
         begin
            state_r <= ecfd_pkg::ST_WAIT;
         end
         else
         begin
            state_r   <= ecfd_pkg::ST_RUN;
            counter_r <= reload_r;
         end
      end
      else
      begin
         case (state_r)
            ecfd_pkg::ST_IDLE: state_r <= ecfd_pkg::ST_IDLE;
            ecfd_pkg::ST_WAIT:
            begin
               if (cnt_step)
               begin
                  counter_r <= reload_r;
                  state_r   <= ecfd_pkg::ST_RUN;
               end
            end
            ecfd_pkg::ST_RUN:
            begin
               if (cnt_step)
               begin
                  counter_r <= (counter_r == 16'h0000) ? reload_r
                                                       : counter_r - 16'h0001;
               end
            end
            default: state_r <= ecfd_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (unit_rst)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= irq_nxt;
      end
   end

   // toggle per reload halves rate
   // With the enable low, only software sets the pin; with it high, only
   // counting moves it, so the two never fight over the same edge.
   always_ff @(posedge clk_i)
   begin
      if (unit_rst)
      begin
         tout_r <= 1'b0;
      end
      else if (!oen_r && wr_ok && adr_w == ecfd_pkg::ADR_OLVL && lane)
      begin
         tout_r <= wb_dat_i[CH_IDX];
      end
      else if (oen_r && irq_nxt)
      begin
         tout_r <= ~tout_r;
      end
   end

   assign eif.edge_sel = mode_r[ecfd_pkg::MD_EDGE_LO +: 2];
   assign eif.enable   = active_r;

   ecfd_opclk #(
      .CH_IDX (CH_IDX)
   ) u_opclk (
      .clk_i   (clk_i),
      .rst_i   (unit_rst),
      .presc_i (presc_r),
      .cks_i   (mode_r[ecfd_pkg::MD_CKS]),
      .ck_if   (eif)
   );

   ecfd_edge_det u_edge (
      .clk_i             (clk_i),
      .rst_i             (unit_rst),
      .event_input_pin_i (event_input_pin_i),
      .det_if            (eif)
   );

   assign wb_ack_o           = ack_r;
   assign wb_dat_o           = dat_r;
   assign timer_output_pin_o = tout_r;
   assign channel_irq_o      = irq_r;

   // ----------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_event_start_load: assert property (
      start_evt |=> state_r == ecfd_pkg::ST_RUN && active_r
                    && counter_r == $past(reload_r))
      else $error("event start did not load the reload value");

   a_run_decrement: assert property (
      state_r == ecfd_pkg::ST_RUN && cnt_step && !halt && !go && counter_r != 16'h0000
      |=> counter_r == $past(counter_r) - 16'h0001)
      else $error("counter did not decrement on a count step");

   a_zero_reload_irq: assert property (
      reload_evt |=> counter_r == $past(reload_r) && channel_irq_o)
      else $error("zero count did not reload and interrupt");

   a_irq_has_cause: assert property (
      channel_irq_o |-> $past(cnt_step) || $past(go))
      else $error("interrupt without a count step or start");

   a_halt_holds: assert property (
      halt |=> !active_r ##1 $stable(counter_r))
      else $error("stop did not clear active or hold counter");

   a_no_start_irq: assert property (
      go && !halt && !start_irq |=> !channel_irq_o)
      else $error("interrupt at start with start bit clear");

   a_fd_first_edge: assert property (
      wait_evt |=> state_r == ecfd_pkg::ST_RUN && counter_r == $past(reload_r)
                   && channel_irq_o == $past(start_irq))
      else $error("first divider edge handled wrongly");

   a_fd_toggle_out: assert property (
      is_fd && reload_evt && oen_r |=> timer_output_pin_o != $past(timer_output_pin_o))
      else $error("divider output did not toggle at reload");

   a_unit_off_clear: assert property (
      !unit_en_r |=> !active_r && counter_r == 16'h0000)
      else $error("unit off did not clear channel state");

   a_fd_channel_only: assert property (
      state_r == ecfd_pkg::ST_WAIT |-> fd_ch)
      else $error("divider wait state on a channel without divider");

   c_event_reload:  cover property (reload_evt && is_event);
   c_fd_first_edge: cover property (wait_evt && start_irq);
   c_halt_running:  cover property (halt && active_r);

endmodule : ecfd_channel

// *** test/ecfd_evt_src.sv ***
`timescale 1ns/1ps
// Event source on the far side: one request gives one high pulse on the pin.
module ecfd_evt_src (
   input  wire logic clk_i,
   input  wire logic req_i,
   output logic      pin_o
);
   logic [3:0] cnt_r = 4'h0;

   // ---------------------------------------------------------------
   // Pulse shaping
   // ---------------------------------------------------------------
   // Levels held long enough to be seen.
   // The high level lasts four cycles, above one tick plus the two sync stages.
   always_ff @(posedge clk_i)
   begin
      if (req_i)
         cnt_r <= 4'h8;
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end

   assign pin_o = (cnt_r > 4'h4);
endmodule : ecfd_evt_src

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat, irq_cnt = 32'h0;
   logic        ack, pin, tout, irq;
   logic [31:0] expq[$];
   int          err_total = 0, n_checks = 0, seed = 32'h6207;
   logic [15:0] r;

   // The clock toggles every half period of 5 ns.
   always #5 clk_i = ~clk_i;

   ecfd_channel i_ecfd_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .event_input_pin_i(pin),
      .timer_output_pin_o(tout), .channel_irq_o(irq));
   ecfd_evt_src i_ecfd_evt_src (.clk_i(clk_i), .req_i(req), .pin_o(pin));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // One classic cycle; a read notes its expected data for the monitor.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      if (!w)
         expq.push_back(d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   // One pin pulse, then enough cycles for sync, tick and count step.
   task automatic evt;
      req <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      repeat (12) @(posedge clk_i);
   endtask : evt

   // Read data is taken at the ack edge and compared with the oldest note.
   always @(posedge clk_i)
   begin
      if (ack === 1'b1 && cyc && !we && expq.size() > 0)
         chk(rdat, expq.pop_front());
      if (irq === 1'b1)
         irq_cnt <= irq_cnt + 32'h1;
   end

   // Watchdog sized well beyond the short sequence below.
   initial
   begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      conclude();
   end

   initial
   begin
      r = 16'(($random(seed) & 3) + 1);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Mode register resets to zero and ignores writes while the unit is off.
      bus(1'b0, ecfd_pkg::ADR_MODE, 32'h0);
      bus(1'b1, ecfd_pkg::ADR_MODE, 32'h1046);
      bus(1'b0, ecfd_pkg::ADR_MODE, 32'h0);
      bus(1'b1, ecfd_pkg::ADR_UNIT, 32'h1);
      bus(1'b1, ecfd_pkg::ADR_PRESC, 32'h0);
      // Pin count source, event mode, rising edge, software start, master 0.
      // Output enable, level and function bits stay 0 from reset in this mode.
      bus(1'b1, ecfd_pkg::ADR_MODE, 32'h1046);
      bus(1'b0, ecfd_pkg::ADR_MODE, 32'h1046);
      bus(1'b1, ecfd_pkg::ADR_RELOAD, {16'h0, r});
      bus(1'b1, ecfd_pkg::ADR_TRIG, 32'h1);
      bus(1'b0, ecfd_pkg::ADR_COUNT, {16'h0, r});
      bus(1'b0, ecfd_pkg::ADR_TRIG, 32'h0);
      bus(1'b0, ecfd_pkg::ADR_STAT, 32'h1);
      // New reload value must wait for the next period; only it changes now.
      bus(1'b1, ecfd_pkg::ADR_RELOAD, {16'h0, r + 16'h3});
      repeat (r) evt();
      bus(1'b0, ecfd_pkg::ADR_COUNT, 32'h0);
      chk(irq_cnt, 32'h0);
      evt();
      bus(1'b0, ecfd_pkg::ADR_COUNT, {16'h0, r + 16'h3});
      chk(irq_cnt, 32'h1);
      // Halt holds the count and ignores further edges.
      bus(1'b1, ecfd_pkg::ADR_TRIG, 32'h2);
      bus(1'b0, ecfd_pkg::ADR_STAT, 32'h0);
      evt();
      bus(1'b0, ecfd_pkg::ADR_COUNT, {16'h0, r + 16'h3});
      chk(irq_cnt, 32'h1);
      bus(1'b1, ecfd_pkg::ADR_UNIT, 32'h0);
      bus(1'b0, ecfd_pkg::ADR_COUNT, 32'h0);
      // Divider mode, falling edge, start interrupt on; a hardware trigger
      // source must leave the software start without effect.
      bus(1'b1, ecfd_pkg::ADR_UNIT, 32'h1);
      bus(1'b1, ecfd_pkg::ADR_MODE, 32'h1101);
      bus(1'b1, ecfd_pkg::ADR_TRIG, 32'h1);
      bus(1'b0, ecfd_pkg::ADR_STAT, 32'h0);
      bus(1'b1, ecfd_pkg::ADR_MODE, 32'h1001);
      bus(1'b1, ecfd_pkg::ADR_RELOAD, 32'h1);
      // With the output enable low, software sets the idle level directly.
      bus(1'b1, ecfd_pkg::ADR_OLVL, 32'h400);
      bus(1'b0, ecfd_pkg::ADR_STAT, 32'h2);
      bus(1'b1, ecfd_pkg::ADR_OEN, 32'h400);
      bus(1'b0, ecfd_pkg::ADR_OEN, 32'h400);
      bus(1'b0, ecfd_pkg::ADR_OPOL, 32'h0);
      bus(1'b1, ecfd_pkg::ADR_TRIG, 32'h1);
      bus(1'b0, ecfd_pkg::ADR_STAT, 32'h3);
      bus(1'b0, ecfd_pkg::ADR_COUNT, 32'h0);
      evt();
      chk(irq_cnt, 32'h2);
      chk(32'(tout), 32'h0);
      bus(1'b0, ecfd_pkg::ADR_COUNT, 32'h1);
      repeat (2) evt();
      chk(32'(tout), 32'h1);
      chk(irq_cnt, 32'h3);
      // Stop before the mode changes; with both edges each pulse toggles once.
      bus(1'b1, ecfd_pkg::ADR_TRIG, 32'h2);
      bus(1'b1, ecfd_pkg::ADR_MODE, 32'h1081);
      bus(1'b1, ecfd_pkg::ADR_TRIG, 32'h1);
      evt();
      chk(32'(tout), 32'h0);
      evt();
      chk(32'(tout), 32'h1);
      chk(irq_cnt, 32'h5);
      // The output is cleared one cycle after the unit enable falls.
      bus(1'b1, ecfd_pkg::ADR_UNIT, 32'h0);
      @(posedge clk_i);
      chk(32'(tout), 32'h0);
      bus(1'b0, 8'h3C, 32'h0);
      conclude();
   end
endmodule : tb
